// File: hw/qlso_map.svh
// constants of the four-channel serial lane output block
// included by the package and the serializer; definitions only
`ifndef QLSO_MAP_SVH
`define QLSO_MAP_SVH

`define QLSO_NCH 4
`define QLSO_SMP_W 12
`define QLSO_SR_W 16
`define QLSO_POS16 5'h10
`define QLSO_POS14 5'h0E
`define QLSO_POS12 5'h0C
`define QLSO_PAD_BITS 2
`define QLSO_MAX_MBPS 1000
`define QLSO_MIN_SER_NS 1

`endif

// File: hw/qlso_pkg.sv
// types of the four-channel serial lane output block
// assumes qlso_map.svh is on the include path
`include "qlso_map.svh"

package qlso_pkg;

    // serialized word length per sample
    typedef enum logic [1:0] {
        QLSO_LEN16,
        QLSO_LEN14,
        QLSO_LEN12
    } qlso_len_t;

    typedef logic [`QLSO_NCH-1:0][`QLSO_SMP_W-1:0] qlso_smp_t;

    // one sample set with the format it is to leave in
    typedef struct packed {
        logic two_lane;
        qlso_len_t len;
        qlso_smp_t smp;
    } qlso_payload_t;

endpackage

// File: hw/qlso_serializer.sv
// four-channel serial lane output: sample side on clk_i, link side on link_clk_i
// assumes link_clk_i is the free-running bit clock, one serial bit per cycle
//
// Overview of operation
// - six formats: one or two lanes, each with 16, 14 or 12 bit positions
// - padded formats add two pad bits after the data, both driven low
// - two lanes at 14 positions: frame marker period spans two samples
// - one-lane formats disable every channel's second lane pair
// - two-lane formats send two bits per channel at once, one per lane
// - one-lane formats send each channel only on its first lane
`timescale 1ns/1ps
`include "qlso_map.svh"

module qlso_serializer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic sample_valid_i,
    input wire qlso_pkg::qlso_smp_t samples_i,
    input wire logic two_lane_i,
    input wire qlso_pkg::qlso_len_t word_len_i,
    output logic sample_ready_o,
    output logic [`QLSO_NCH-1:0] lane_a_o,
    output logic [`QLSO_NCH-1:0] lane_b_o,
    output logic lane_b_en_o,
    output logic frame_marker_o,
    output logic forwarded_bit_clock_o
);
    // sample side: toggle handshake, payload held until acknowledged
    qlso_pkg::qlso_payload_t pay_q, pay_d;
    logic req_q, req_d;
    logic ack_q, ack_d;
    logic ack_sync;

    qlso_sync3 #(.W(1)) u_ack_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(ack_q),
        .q_o(ack_sync)
    );

    assign sample_ready_o = (req_q == ack_sync);

    always_comb begin
        pay_d = pay_q;
        req_d = req_q;
        if (sample_valid_i && sample_ready_o) begin
            pay_d.two_lane = two_lane_i;
            pay_d.len = word_len_i;
            pay_d.smp = samples_i;
            req_d = ~req_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pay_q <= '0;
            req_q <= 1'b0;
        end else begin
            pay_q <= pay_d;
            req_q <= req_d;
        end
    end

    // link side reset: asserted at once, released on the link clock
    logic lrst1_q, lrst_n_q;

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lrst1_q <= 1'b0;
            lrst_n_q <= 1'b0;
        end else begin
            lrst1_q <= 1'b1;
            lrst_n_q <= lrst1_q;
        end
    end

    function automatic logic [4:0] plen(input logic two, input qlso_pkg::qlso_len_t len);
        logic [4:0] n;
        case (len)
            qlso_pkg::QLSO_LEN16: n = `QLSO_POS16;
            qlso_pkg::QLSO_LEN14: n = `QLSO_POS14;
            default: n = `QLSO_POS12;
        endcase
        plen = two ? (n >> 1) : n;
    endfunction

    logic req_lvl;
    qlso_pkg::qlso_payload_t hold_q, hold_d;
    logic [`QLSO_NCH-1:0][`QLSO_SR_W-1:0] sr_q, sr_d;
    logic [4:0] cnt_q, cnt_d;
    logic par_q, par_d;
    logic two_q, two_d;
    qlso_pkg::qlso_len_t len_q, len_d;
    logic [`QLSO_NCH-1:0] la_q, la_d, lb_q, lb_d;
    logic lben_q, lben_d, fr_q, fr_d, fclk_q, fclk_d;
    logic [4:0] pos_cur, pos_nxt;
    logic last;

    qlso_sync3 #(.W(1)) u_req_sync (
        .clk_i(link_clk_i),
        .rst_n_i(lrst_n_q),
        .d_i(req_q),
        .q_o(req_lvl)
    );

    assign pos_cur = plen(two_q, len_q);
    assign last = (cnt_q == pos_cur - 5'h01);

    always_comb begin
        ack_d = ack_q;
        hold_d = hold_q;
        sr_d = sr_q;
        cnt_d = cnt_q + 5'h01;
        par_d = par_q;
        two_d = two_q;
        len_d = len_q;
        // payload is stable while req and ack differ
        if (req_lvl != ack_q) begin
            hold_d = pay_q;
            ack_d = req_lvl;
        end
        if (last) begin
            // mode and sample switch only at a frame boundary; idle repeats the last set
            cnt_d = 5'h00;
            par_d = ~par_q;
            two_d = hold_q.two_lane;
            len_d = hold_q.len;
            for (int c = 0; c < `QLSO_NCH; c++) begin
                // left aligned: pads and filler trail the data as zeros
                sr_d[c] = {hold_q.smp[c], 4'h0};
            end
        end else begin
            for (int c = 0; c < `QLSO_NCH; c++) begin
                sr_d[c] = two_q ? (sr_q[c] << 2) : (sr_q[c] << 1);
            end
        end
        pos_nxt = plen(two_d, len_d);
        for (int c = 0; c < `QLSO_NCH; c++) begin
            la_d[c] = sr_d[c][`QLSO_SR_W-1];
            lb_d[c] = two_d & sr_d[c][`QLSO_SR_W-2];
        end
        lben_d = two_d;
        if (two_d && len_d == qlso_pkg::QLSO_LEN14) begin
            // odd half-frame, so the marker spans two samples
            fr_d = ~par_d;
        end else begin
            fr_d = (cnt_d < (pos_nxt >> 1));
        end
        // one toggle per bit: receiver takes data on both edges
        fclk_d = ~fclk_q;
    end

    always_ff @(posedge link_clk_i or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            ack_q <= 1'b0;
            hold_q <= '{two_lane: 1'b1, len: qlso_pkg::QLSO_LEN16, smp: '0};
            sr_q <= '0;
            cnt_q <= 5'h00;
            par_q <= 1'b0;
            two_q <= 1'b1;
            len_q <= qlso_pkg::QLSO_LEN16;
            la_q <= '0;
            lb_q <= '0;
            lben_q <= 1'b1;
            fr_q <= 1'b1;
            fclk_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            hold_q <= hold_d;
            sr_q <= sr_d;
            cnt_q <= cnt_d;
            par_q <= par_d;
            two_q <= two_d;
            len_q <= len_d;
            la_q <= la_d;
            lb_q <= lb_d;
            lben_q <= lben_d;
            fr_q <= fr_d;
            fclk_q <= fclk_d;
        end
    end

    assign lane_a_o = la_q;
    assign lane_b_o = lb_q;
    assign lane_b_en_o = lben_q;
    assign frame_marker_o = fr_q;
    assign forwarded_bit_clock_o = fclk_q;

    a_lane_b_off: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        !two_q |-> (!lane_b_en_o && lane_b_o == '0))
        else $error("second lane active in one-lane format");

    a_lane_b_on: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        two_q |-> lane_b_en_o)
        else $error("second lane off in two-lane format");

    a_frame_wrap: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (cnt_q == plen(two_q, len_q) - 5'h01) |=> (cnt_q == 5'h00))
        else $error("frame length wrong for format");

    a_count_range: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        cnt_q < plen(two_q, len_q))
        else $error("bit position past frame end");

    a_marker_two14_hi: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (two_q && len_q == qlso_pkg::QLSO_LEN14 && cnt_q == 5'h00 && !par_q)
        |-> frame_marker_o [*7])
        else $error("marker not high for whole even frame");

    a_marker_two14_lo: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (two_q && len_q == qlso_pkg::QLSO_LEN14 && cnt_q == 5'h00 && par_q)
        |-> !frame_marker_o [*7])
        else $error("marker not low for whole odd frame");

    // state first moves one link edge after release, so that edge starts no attempt
    a_marker_two16: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (lrst_n_q && two_q && len_q == qlso_pkg::QLSO_LEN16 && cnt_q == 5'h00)
        |-> frame_marker_o [*4] ##1 !frame_marker_o [*4])
        else $error("marker shape wrong in two-lane 16");

    a_pad_two14: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (two_q && len_q == qlso_pkg::QLSO_LEN14 && cnt_q == 5'h06)
        |-> (lane_a_o == '0 && lane_b_o == '0))
        else $error("pad bits not low in two-lane 14");

    a_pad_one16: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (!two_q && len_q == qlso_pkg::QLSO_LEN16 && cnt_q == 5'h0C)
        |-> (lane_a_o == '0) [*4])
        else $error("trailing bits not low in one-lane 16");

    a_mode_frame: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        (cnt_q != plen(two_q, len_q) - 5'h01) |=> ($stable(two_q) && $stable(len_q)))
        else $error("format changed inside a frame");

    a_fclk_toggle: assert property (
        @(posedge link_clk_i) disable iff (!lrst_n_q)
        lrst_n_q |=> (forwarded_bit_clock_o != $past(forwarded_bit_clock_o)))
        else $error("forwarded clock missed a toggle");

endmodule

// File: hw/qlso_sync3.sv
// three-flop level synchroniser with agreement filter
// assumes d_i is quasi-static between changes
`timescale 1ns/1ps

module qlso_sync3 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

    // a change counts only once the last two stages agree
    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s3_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign q_o = lvl_q;

endmodule

// File: test/qlso_rx_model.sv
// receiver model: deserializes the four channels, aligned on the frame marker
// assumes its format inputs follow the set last handed to the serializer
`timescale 1ns/1ps

module qlso_rx_model (
    input wire logic link_clk_i,
    input wire logic [3:0] lane_a_i,
    input wire logic [3:0] lane_b_i,
    input wire logic lane_b_en_i,
    input wire logic frame_marker_i,
    input wire logic fwd_clk_i,
    input wire logic two_lane_i,
    input wire logic [4:0] len_i,
    output logic [3:0][15:0] word_o,
    output int frames_o,
    output int gap_o,
    output int err_o
);
    logic [3:0][15:0] sh = '0;
    logic m_q = 1'b1;
    logic f_q = 1'b0;
    int cnt = 0;
    int since = 0;
    int pos;

    initial begin
        word_o = '0;
        frames_o = 0;
        gap_o = 0;
        err_o = 0;
    end

    always @(posedge link_clk_i) begin
        pos = two_lane_i ? len_i / 2 : len_i;
        for (int c = 0; c < 4; c++) begin
            sh[c] = two_lane_i ? {sh[c][13:0], lane_a_i[c], lane_b_i[c]}
                               : {sh[c][14:0], lane_a_i[c]};
        end
        // a rising marker starts position 0; the gap between rises is the marker period
        if (frame_marker_i && !m_q) begin
            gap_o = since;
            since = 1;
            cnt = 0;
        end else begin
            since++;
            cnt = (cnt >= pos - 1) ? 0 : cnt + 1;
        end
        if (cnt == pos - 1) begin
            for (int c = 0; c < 4; c++) begin
                word_o[c] = sh[c] & ((16'h0001 << len_i) - 16'h0001);
            end
            frames_o++;
        end
        // a quiet second lane is only asked for in one-lane formats
        if (!two_lane_i && (lane_b_en_i !== 1'b0 || lane_b_i !== 4'h0)) begin
            err_o++;
        end
        if (fwd_clk_i === f_q) begin
            err_o++;
        end
        m_q = frame_marker_i;
        f_q = fwd_clk_i;
    end
endmodule

// File: test/test_quad_adc_serial_lane_output.sv
// testbench of the four-channel serial lane output block
// assumes the receiver model of qlso_rx_model.sv on the link side
`timescale 1ns/1ps

module test_quad_adc_serial_lane_output;
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sample_valid_i = 1'b0;
    qlso_pkg::qlso_smp_t samples_i = '0;
    logic two_lane_i = 1'b1;
    qlso_pkg::qlso_len_t word_len_i = qlso_pkg::QLSO_LEN16;
    logic sample_ready_o;
    logic [3:0] lane_a_o;
    logic [3:0] lane_b_o;
    logic lane_b_en_o;
    logic frame_marker_o;
    logic forwarded_bit_clock_o;
    logic [3:0][15:0] word;
    logic [4:0] len = 5'h10;
    int frames;
    int gap;
    int err;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #50 clk_i = ~clk_i;
    always #16 link_clk_i = ~link_clk_i;

    qlso_serializer qlso_serializer_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link_clk_i(link_clk_i), .sample_valid_i(sample_valid_i), .samples_i(samples_i),
        .two_lane_i(two_lane_i), .word_len_i(word_len_i), .sample_ready_o(sample_ready_o),
        .lane_a_o(lane_a_o), .lane_b_o(lane_b_o), .lane_b_en_o(lane_b_en_o),
        .frame_marker_o(frame_marker_o), .forwarded_bit_clock_o(forwarded_bit_clock_o));

    qlso_rx_model qlso_rx_model_i (.link_clk_i(link_clk_i), .lane_a_i(lane_a_o),
        .lane_b_i(lane_b_o), .lane_b_en_i(lane_b_en_o), .frame_marker_i(frame_marker_o),
        .fwd_clk_i(forwarded_bit_clock_o), .two_lane_i(two_lane_i), .len_i(len),
        .word_o(word), .frames_o(frames), .gap_o(gap), .err_o(err));

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // the link side takes a set, then ends the old frame; 64 bit times cover that
    // plus two marker periods of the new format, so the model has realigned
    task automatic settle();
        @(posedge clk_i);
        for (int i = 0; i < 100 && sample_ready_o !== 1'b1; i++) @(posedge clk_i);
        repeat (64) @(posedge link_clk_i);
    endtask

    task automatic send(qlso_pkg::qlso_smp_t s, logic two, qlso_pkg::qlso_len_t l, int n);
        @(posedge clk_i);
        for (int i = 0; i < 100 && sample_ready_o !== 1'b1; i++) @(posedge clk_i);
        sample_valid_i <= 1'b1;
        samples_i <= s;
        two_lane_i <= two;
        word_len_i <= l;
        len <= 5'(n);
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
    endtask

    // one format: distinct data per channel, words, marker period, lane B, bit clock
    task automatic run_fmt(logic two, qlso_pkg::qlso_len_t l, int n, logic [11:0] base);
        qlso_pkg::qlso_smp_t s;
        int e0;
        for (int c = 0; c < 4; c++) s[c] = base + 12'(c * 291);
        send(s, two, l, n);
        settle();
        e0 = err;
        for (int c = 0; c < 4; c++) check("word", 16'(s[c]) << (n - 12), word[c]);
        check("marker period", 16'((two && n == 14) ? 14 : (two ? n / 2 : n)), 16'(gap));
        check("lane b enable", {15'h0000, two}, {15'h0000, lane_b_en_o});
        repeat (32) @(posedge link_clk_i);
        check("lane faults", 16'(e0), 16'(err));
    endtask

    // a set offered while ready is low is dropped; the taken set streams on
    task automatic refuse_test();
        qlso_pkg::qlso_smp_t s;
        s = {12'h123, 12'h456, 12'h789, 12'hABC};
        send(s, 1'b0, qlso_pkg::QLSO_LEN12, 12);
        @(posedge clk_i);
        check("ready low", 16'h0000, {15'h0000, sample_ready_o});
        sample_valid_i <= 1'b1;
        samples_i <= '1;
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        settle();
        for (int c = 0; c < 4; c++) check("kept word", 16'(s[c]), word[c]);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // whole run is a few hundred sample cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        run_fmt(1'b1, qlso_pkg::QLSO_LEN16, 16, 12'hA5C);
        run_fmt(1'b1, qlso_pkg::QLSO_LEN14, 14, 12'h3F1);
        run_fmt(1'b1, qlso_pkg::QLSO_LEN12, 12, 12'h8E7);
        run_fmt(1'b0, qlso_pkg::QLSO_LEN16, 16, 12'hF0D);
        run_fmt(1'b0, qlso_pkg::QLSO_LEN14, 14, 12'h0C3);
        run_fmt(1'b0, qlso_pkg::QLSO_LEN12, 12, 12'h6B2);
        run_fmt(1'b1, qlso_pkg::QLSO_LEN14, 14, 12'hFFF);
        refuse_test();
        print_verdict();
    end
endmodule
